// >>> common/mgbd_pkg.sv
package mgbd_pkg;
	// Description byte offsets handled by this block
	localparam logic [7:0] MGBD_OFS_COL = 8'h04;
	localparam logic [7:0] MGBD_OFS_ROWS = 8'h05;
	localparam logic [7:0] MGBD_OFS_WLO = 8'h06;
	localparam logic [7:0] MGBD_OFS_WHI = 8'h07;
	localparam logic [7:0] MGBD_OFS_LVL = 8'h08;
	localparam logic [7:0] MGBD_OFS_TCK = 8'h09;
	localparam logic [7:0] MGBD_OFS_TAC = 8'h0A;
	localparam logic [7:0] MGBD_OFS_ERR = 8'h0B;
	localparam logic [7:0] MGBD_OFS_REF = 8'h0C;
	localparam logic [7:0] MGBD_OFS_PWID = 8'h0D;
	localparam logic [7:0] MGBD_OFS_CAS = 8'h12;
	// Common values
	localparam logic [7:0] MGBD_BYTE_ZERO = 8'h00;
	localparam logic [3:0] MGBD_NIB_ZERO = 4'h0;
	localparam logic [4:0] MGBD_COLS_ZERO = 5'h00;
	// Column nibble roll-up codes and their bit counts
	localparam logic [3:0] MGBD_COL_RU1 = 4'h1;
	localparam logic [3:0] MGBD_COL_RU2 = 4'h2;
	localparam logic [3:0] MGBD_COL_MIN = 4'h7;
	localparam logic [4:0] MGBD_COLS_RU1 = 5'h10;
	localparam logic [4:0] MGBD_COLS_RU2 = 5'h11;
	// Interface levels
	typedef enum logic [2:0] {
		MGBD_LVL_TTL5 = 3'h0,
		MGBD_LVL_LVTTL = 3'h1,
		MGBD_LVL_HSTL15 = 3'h2,
		MGBD_LVL_SSTL33 = 3'h3,
		MGBD_LVL_SSTL25 = 3'h4,
		MGBD_LVL_NEWTAB = 3'h5,
		MGBD_LVL_UNDEF = 3'h7
	} mgbd_lvl_t;
	localparam logic [7:0] MGBD_LVL_MAXCODE = 8'h04;
	localparam logic [7:0] MGBD_LVL_NEWCODE = 8'hFF;
	// Error schemes
	typedef enum logic [1:0] {
		MGBD_ERR_NONE = 2'h0,
		MGBD_ERR_PARITY = 2'h1,
		MGBD_ERR_ECC = 2'h2,
		MGBD_ERR_UNDEF = 2'h3
	} mgbd_err_t;
	localparam logic [7:0] MGBD_ERR_MAXCODE = 8'h02;
	// Refresh byte fields
	localparam int MGBD_SELF_BIT = 7;
	localparam logic [6:0] MGBD_REF_MAXCODE = 7'h05;
	localparam logic [6:0] MGBD_REF_ZERO = 7'h00;
	// Width byte fields
	localparam int MGBD_DBL_BIT = 7;
	localparam logic [6:0] MGBD_PWID_ZERO = 7'h00;
	// Nibble time: whole ns in high nibble, tenths in low nibble
	localparam logic [7:0] MGBD_TENTHS_PER_NS = 8'h0A;
	localparam logic [2:0] MGBD_CAS_NONE = 3'h0;
endpackage

// >>> hdl/mgbd_col_nib.sv
`timescale 1ns/10ps
`default_nettype none
// Turns one column-count nibble into a bit count and a validity flag
module mgbd_col_nib
	import mgbd_pkg::*;
(
	// Code in
	input wire logic [3:0] nib,
	// Decoded out
	output logic [4:0] bits,
	output logic bad
);
	// Codes 3 to 6 carry no defined count
	wire is_direct = (nib >= MGBD_COL_MIN);
	wire is_ru1 = (nib == MGBD_COL_RU1);
	wire is_ru2 = (nib == MGBD_COL_RU2);
	// Roll-up codes report the large reading; 1-3 bits never occur
	assign bits = is_direct ? {1'b0, nib} :
		is_ru1 ? MGBD_COLS_RU1 :
		is_ru2 ? MGBD_COLS_RU2 : MGBD_COLS_ZERO;
	assign bad = !(is_direct || is_ru1 || is_ru2);
endmodule
`default_nettype wire

// >>> hdl/mgbd_nib_time.sv
`timescale 1ns/10ps
`default_nettype none
// Nibble-coded time to tenths of a nanosecond
module mgbd_nib_time
	import mgbd_pkg::*;
(
	// Coded byte in
	input wire logic [7:0] code,
	// Time in units of 0.1 ns
	output logic [7:0] tenths,
	output logic bad
);
	// Product of nibble by ten fits in 8 bits (max 150 + 15)
	wire [11:0] whole_x10 = 12'(code[7:4]) * 12'(MGBD_TENTHS_PER_NS);
	wire [11:0] sum = whole_x10 + {8'h00, code[3:0]};
	assign tenths = sum[7:0];
	// A zero period tells nothing usable
	assign bad = (code == MGBD_BYTE_ZERO);
endmodule
`default_nettype wire

// >>> hdl/mgbd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
//Behaviour
//- Equal banks: low nibble columns, high zero
//- Unequal banks: low nibble bank1, high bank2
//- Column count excludes bank selects, auto-precharge
//- Nibble 0 undefined; 1,2 roll-up; 7-F direct
//- Row byte binary count; zero undefined
//- Width sixteen bits, byte 6 low; zero undefined
//- Level codes 00-04 decoded; FF new table
//- Cycle time: high ns plus low tenths
//- Access time uses same nibble encoding
//- Error scheme none, parity, ECC; rest invalid
//- Refresh code bits 6-0, bit 7 self refresh
//- Refresh codes 00-05 mapped; higher undefined
//- Primary width bits 6-0; zero undefined
//- Bit 7 flags second bank double width
//- Highest set CAS bit of bits 6-0 names reference latency
module mgbd_decoder
	import mgbd_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// Incoming description byte
	input wire logic BYTE_VALID,
	input wire logic [7:0] BYTE_OFFSET,
	input wire logic [7:0] BYTE_DATA,
	// Column geometry
	output logic [4:0] COL_BITS_BANK1,
	output logic [4:0] COL_BITS_BANK2,
	output logic COL_BANKS_DIFFER,
	output logic COL_INVALID,
	// Module rows and width
	output logic [7:0] ROW_COUNT,
	output logic ROW_INVALID,
	output logic [15:0] MODULE_WIDTH,
	output logic WIDTH_INVALID,
	// Interface level
	output logic [2:0] LEVEL,
	output logic LEVEL_INVALID,
	// Timing at highest CAS latency, 0.1 ns units
	output logic [7:0] TCK_MIN_TENTHS,
	output logic TCK_INVALID,
	output logic [7:0] TAC_MAX_TENTHS,
	output logic TAC_INVALID,
	output logic [2:0] CAS_REF_LATENCY,
	output logic CAS_INVALID,
	// Error scheme
	output logic [1:0] ERR_SCHEME,
	output logic ERR_INVALID,
	// Refresh
	output logic [6:0] REFRESH_CODE,
	output logic SELF_REFRESH,
	output logic REFRESH_INVALID,
	// Primary device width
	output logic [6:0] PRIM_WIDTH,
	output logic PRIM_DOUBLE_BANK2,
	output logic PRIM_INVALID
);
	// Raw byte capture registers, cleared to zero
	logic [7:0] col_r, rows_r, wlo_r, whi_r, lvl_r;
	logic [7:0] tck_r, tac_r, err_r, ref_r, pwid_r, cas_r;
	// Level byte written flag, keeps an unwritten level apart from code 00
	logic lvl_seen_r;

	// Write strobes per offset
	wire wr_col = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_COL);
	wire wr_rows = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_ROWS);
	wire wr_wlo = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_WLO);
	wire wr_whi = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_WHI);
	wire wr_lvl = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_LVL);
	wire wr_tck = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_TCK);
	wire wr_tac = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_TAC);
	wire wr_err = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_ERR);
	wire wr_ref = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_REF);
	wire wr_pwid = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_PWID);
	wire wr_cas = BYTE_VALID && (BYTE_OFFSET == MGBD_OFS_CAS);

	// Capture of each byte; other offsets are ignored
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			col_r <= MGBD_BYTE_ZERO;
			rows_r <= MGBD_BYTE_ZERO;
			wlo_r <= MGBD_BYTE_ZERO;
			whi_r <= MGBD_BYTE_ZERO;
			lvl_r <= MGBD_BYTE_ZERO;
			lvl_seen_r <= 1'b0;
			tck_r <= MGBD_BYTE_ZERO;
			tac_r <= MGBD_BYTE_ZERO;
			err_r <= MGBD_BYTE_ZERO;
			ref_r <= MGBD_BYTE_ZERO;
			pwid_r <= MGBD_BYTE_ZERO;
			cas_r <= MGBD_BYTE_ZERO;
		end else begin
			if (wr_col) col_r <= BYTE_DATA;
			if (wr_rows) rows_r <= BYTE_DATA;
			if (wr_wlo) wlo_r <= BYTE_DATA;
			if (wr_whi) whi_r <= BYTE_DATA;
			if (wr_lvl) lvl_r <= BYTE_DATA;
			if (wr_lvl) lvl_seen_r <= 1'b1;
			if (wr_tck) tck_r <= BYTE_DATA;
			if (wr_tac) tac_r <= BYTE_DATA;
			if (wr_err) err_r <= BYTE_DATA;
			if (wr_ref) ref_r <= BYTE_DATA;
			if (wr_pwid) pwid_r <= BYTE_DATA;
			if (wr_cas) cas_r <= BYTE_DATA;
		end
	end

	// Column nibble decode, one instance per bank
	logic [4:0] c1_bits, c2_bits;
	logic c1_bad, c2_bad;
	mgbd_col_nib u_col1 (
		.nib(col_r[3:0]),
		.bits(c1_bits),
		.bad(c1_bad)
	);
	mgbd_col_nib u_col2 (
		.nib(col_r[7:4]),
		.bits(c2_bits),
		.bad(c2_bad)
	);
	// A zero high nibble means both banks share the low count
	wire col_same = (col_r[7:4] == MGBD_NIB_ZERO);
	// Count excludes bank_select_0/1 and auto-precharge bit
	wire [4:0] col1_nxt = c1_bits;
	wire [4:0] col2_nxt = col_same ? c1_bits : c2_bits;
	wire col_bad_nxt = c1_bad || (!col_same && c2_bad);

	// Rows and width checks
	wire rows_bad_nxt = (rows_r == MGBD_BYTE_ZERO);
	wire [15:0] width_nxt = {whi_r, wlo_r};
	// Both halves zero is the only undefined width
	wire width_bad_nxt =
		(width_nxt == {MGBD_BYTE_ZERO, MGBD_BYTE_ZERO});

	// Interface level decode
	logic [2:0] lvl_nxt;
	always_comb begin
		lvl_nxt = MGBD_LVL_UNDEF;
		if (lvl_r <= MGBD_LVL_MAXCODE) begin
			lvl_nxt = lvl_r[2:0];
		end else if (lvl_r == MGBD_LVL_NEWCODE) begin
			lvl_nxt = MGBD_LVL_NEWTAB;
		end
	end
	// Unwritten level is undefined, not 5 V TTL
	wire [2:0] lvl_eff = lvl_seen_r ? lvl_nxt : MGBD_LVL_UNDEF;
	wire lvl_bad_nxt = (lvl_eff == MGBD_LVL_UNDEF) ||
		(lvl_eff == MGBD_LVL_NEWTAB);

	// Timing nibble conversions
	logic [7:0] tck_nxt, tac_nxt;
	logic tck_bad_nxt, tac_bad_nxt;
	mgbd_nib_time u_tck (
		.code(tck_r),
		.tenths(tck_nxt),
		.bad(tck_bad_nxt)
	);
	mgbd_nib_time u_tac (
		.code(tac_r),
		.tenths(tac_nxt),
		.bad(tac_bad_nxt)
	);

	// Highest supported CAS latency; bit n means latency n+1
	logic [2:0] cas_nxt;
	always_comb begin
		cas_nxt = MGBD_CAS_NONE;
		for (int i = 0; i < 7; i++) begin
			if (cas_r[i]) cas_nxt = 3'(i + 1);
		end
	end
	wire cas_bad_nxt = (cas_nxt == MGBD_CAS_NONE);

	// Error scheme; codes above 02 never pass as valid
	wire err_ok = (err_r <= MGBD_ERR_MAXCODE);
	wire [1:0] err_nxt = err_ok ? err_r[1:0] : MGBD_ERR_UNDEF;

	// Refresh fields
	wire [6:0] ref_code = ref_r[6:0];
	wire ref_bad_nxt = (ref_code > MGBD_REF_MAXCODE);
	wire [6:0] ref_out = ref_bad_nxt ? MGBD_REF_ZERO : ref_code;

	// Primary width fields
	wire pwid_bad_nxt = (pwid_r[6:0] == MGBD_PWID_ZERO);

	// Decoded output registers; follow the raw bytes one edge later
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			COL_BITS_BANK1 <= MGBD_COLS_ZERO;
			COL_BITS_BANK2 <= MGBD_COLS_ZERO;
			COL_BANKS_DIFFER <= 1'b0;
			COL_INVALID <= 1'b1;
			ROW_COUNT <= MGBD_BYTE_ZERO;
			ROW_INVALID <= 1'b1;
			MODULE_WIDTH <= {MGBD_BYTE_ZERO, MGBD_BYTE_ZERO};
			WIDTH_INVALID <= 1'b1;
			LEVEL <= MGBD_LVL_UNDEF;
			LEVEL_INVALID <= 1'b1;
			TCK_MIN_TENTHS <= MGBD_BYTE_ZERO;
			TCK_INVALID <= 1'b1;
			TAC_MAX_TENTHS <= MGBD_BYTE_ZERO;
			TAC_INVALID <= 1'b1;
			CAS_REF_LATENCY <= MGBD_CAS_NONE;
			CAS_INVALID <= 1'b1;
			ERR_SCHEME <= MGBD_ERR_UNDEF;
			ERR_INVALID <= 1'b1;
			REFRESH_CODE <= MGBD_REF_ZERO;
			SELF_REFRESH <= 1'b0;
			REFRESH_INVALID <= 1'b1;
			PRIM_WIDTH <= MGBD_PWID_ZERO;
			PRIM_DOUBLE_BANK2 <= 1'b0;
			PRIM_INVALID <= 1'b1;
		end else begin
			COL_BITS_BANK1 <= col1_nxt;
			COL_BITS_BANK2 <= col2_nxt;
			COL_BANKS_DIFFER <= !col_same;
			COL_INVALID <= col_bad_nxt;
			ROW_COUNT <= rows_r;
			ROW_INVALID <= rows_bad_nxt;
			MODULE_WIDTH <= width_nxt;
			WIDTH_INVALID <= width_bad_nxt;
			LEVEL <= lvl_eff;
			LEVEL_INVALID <= lvl_bad_nxt;
			TCK_MIN_TENTHS <= tck_nxt;
			TCK_INVALID <= tck_bad_nxt;
			TAC_MAX_TENTHS <= tac_nxt;
			TAC_INVALID <= tac_bad_nxt;
			CAS_REF_LATENCY <= cas_nxt;
			CAS_INVALID <= cas_bad_nxt;
			ERR_SCHEME <= err_nxt;
			ERR_INVALID <= !err_ok;
			REFRESH_CODE <= ref_out;
			SELF_REFRESH <= ref_r[MGBD_SELF_BIT];
			REFRESH_INVALID <= ref_bad_nxt;
			PRIM_WIDTH <= pwid_r[6:0];
			PRIM_DOUBLE_BANK2 <= pwid_r[MGBD_DBL_BIT];
			PRIM_INVALID <= pwid_bad_nxt;
		end
	end

	// Checks on the decoded outputs
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	a_col_same_low: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_COL &&
		BYTE_DATA[7:4] == 4'h0 && BYTE_DATA[3:0] == 4'h9
		|=> ##1 COL_BITS_BANK1 == 5'h09 && COL_BITS_BANK2 == 5'h09)
		else $error("equal-bank column count wrong");
	a_col_split_banks: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_COL &&
		BYTE_DATA == 8'h98
		|=> ##1 COL_BITS_BANK1 == 5'h08 && COL_BITS_BANK2 == 5'h09 &&
		COL_BANKS_DIFFER)
		else $error("split-bank column count wrong");
	a_col_rollup_code: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_COL && BYTE_DATA == 8'h01
		|=> ##1 COL_BITS_BANK1 == 5'h10 && !COL_INVALID)
		else $error("roll-up column code wrong");
	a_col_gap_bad: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_COL && BYTE_DATA == 8'h05
		|=> ##1 COL_INVALID)
		else $error("gap column code not flagged");
	a_rows_zero_bad: assert property (
		wr_rows |=> ##1 ROW_COUNT == $past(BYTE_DATA, 2) &&
		ROW_INVALID == ($past(BYTE_DATA, 2) == 8'h00))
		else $error("row invalid flag mismatch");
	a_width_pair: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_WHI && BYTE_DATA == 8'h01
		|=> ##1 MODULE_WIDTH[15:8] == 8'h01 && !WIDTH_INVALID)
		else $error("width high byte not placed");
	a_level_newtab: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_LVL && BYTE_DATA == 8'hFF
		|=> ##1 LEVEL == MGBD_LVL_NEWTAB)
		else $error("new table code not decoded");
	a_tck_tenths: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_TCK && BYTE_DATA == 8'h75
		|=> ##1 TCK_MIN_TENTHS == 8'h4B)
		else $error("cycle time decode wrong");
	a_tac_tenths: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_TAC && BYTE_DATA == 8'h54
		|=> ##1 TAC_MAX_TENTHS == 8'h36)
		else $error("access time decode wrong");
	a_err_undef: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_ERR && BYTE_DATA > 8'h02
		|=> ##1 ERR_INVALID && ERR_SCHEME == MGBD_ERR_UNDEF)
		else $error("undefined error scheme accepted");
	a_self_ref_flag: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_REF
		|=> ##1 SELF_REFRESH == $past(BYTE_DATA[7], 2))
		else $error("self refresh flag wrong");
	a_ref_code_bad: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_REF && BYTE_DATA[6:0] > 7'h05
		|=> ##1 REFRESH_INVALID)
		else $error("undefined refresh code accepted");
	a_prim_double: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_PWID
		|=> ##1 PRIM_DOUBLE_BANK2 == $past(BYTE_DATA[7], 2) &&
		PRIM_WIDTH == $past(BYTE_DATA[6:0], 2))
		else $error("primary width fields wrong");
	a_cas_highest: assert property (
		BYTE_VALID && BYTE_OFFSET == MGBD_OFS_CAS && BYTE_DATA == 8'h06
		|=> ##1 CAS_REF_LATENCY == 3'h3)
		else $error("highest CAS latency wrong");

	c_split_banks: cover property (COL_BANKS_DIFFER && !COL_INVALID);
	c_ecc_module: cover property (ERR_SCHEME == MGBD_ERR_ECC);
	c_self_refresh: cover property (SELF_REFRESH && !REFRESH_INVALID);
	c_double_width: cover property (PRIM_DOUBLE_BANK2);
endmodule
`default_nettype wire

// >>> testbench/mgbd_byte_src.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the description memory reader that feeds the decoder
module mgbd_byte_src
	import mgbd_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Request from the bench
	input wire logic send,
	input wire logic [7:0] s_ofs,
	input wire logic [7:0] s_dat,
	// Byte bus toward the decoder
	output logic valid,
	output logic [7:0] ofs,
	output logic [7:0] dat
);
	// One-cycle byte pulse per request, back to back if asked
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			valid <= 1'b0;
			ofs <= 8'h00;
			dat <= 8'h00;
		end else begin
			valid <= send;
			// Between bytes the lines toggle each cycle: old byte inverted, then the old byte
			ofs <= send ? s_ofs : ~ofs;
			dat <= send ? s_dat : ~dat;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/module_geometry_byte_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the description byte decoder
module module_geometry_byte_decoder_bench
	import mgbd_pkg::*;
;
	// Stimulus side
	logic clock = 1'b0;
	logic rst_b, send;
	logic [7:0] s_ofs, s_dat;
	logic byte_valid;
	logic [7:0] byte_ofs, byte_dat;
	// Decoded outputs
	logic [4:0] col1, col2;
	logic col_dif, col_inv, row_inv, wid_inv, lvl_inv, tck_inv, tac_inv;
	logic cas_inv, err_inv, self_ref, ref_inv, dbl, prim_inv;
	logic [7:0] rows, tck, tac;
	logic [15:0] width;
	logic [2:0] lvl, cas;
	logic [1:0] err;
	logic [6:0] refc, prim;
	// Score keeping
	int n_errors = 0;
	int n_compared = 0;

	// 10 MHz clock
	always #50 clock = ~clock;

	mgbd_byte_src src (.clock(clock), .rst_b(rst_b), .send(send),
		.s_ofs(s_ofs), .s_dat(s_dat), .valid(byte_valid),
		.ofs(byte_ofs), .dat(byte_dat));

	mgbd_decoder uut (.CLOCK(clock), .RST_B(rst_b),
		.BYTE_VALID(byte_valid), .BYTE_OFFSET(byte_ofs),
		.BYTE_DATA(byte_dat), .COL_BITS_BANK1(col1),
		.COL_BITS_BANK2(col2), .COL_BANKS_DIFFER(col_dif),
		.COL_INVALID(col_inv), .ROW_COUNT(rows), .ROW_INVALID(row_inv),
		.MODULE_WIDTH(width), .WIDTH_INVALID(wid_inv), .LEVEL(lvl),
		.LEVEL_INVALID(lvl_inv), .TCK_MIN_TENTHS(tck),
		.TCK_INVALID(tck_inv), .TAC_MAX_TENTHS(tac),
		.TAC_INVALID(tac_inv), .CAS_REF_LATENCY(cas),
		.CAS_INVALID(cas_inv), .ERR_SCHEME(err), .ERR_INVALID(err_inv),
		.REFRESH_CODE(refc), .SELF_REFRESH(self_ref),
		.REFRESH_INVALID(ref_inv), .PRIM_WIDTH(prim),
		.PRIM_DOUBLE_BANK2(dbl), .PRIM_INVALID(prim_inv));

	// Value compare
	task automatic cv(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Flag compare
	task automatic cf(input logic g, input logic e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Queue one byte request; several calls run back to back
	task automatic put(input logic [7:0] o, input logic [7:0] d);
		@(posedge clock);
		send <= 1'b1;
		s_ofs <= o;
		s_dat <= d;
	endtask

	// Stop sending, then wait out source stage plus two-cycle answer
	task automatic idle;
		@(posedge clock);
		send <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask

	// Expected bit count of one column nibble
	function automatic logic [4:0] colx(input logic [3:0] n);
		if (n == 4'h1) return 5'h10;
		if (n == 4'h2) return 5'h11;
		if (n >= 4'h7) return {1'b0, n};
		return 5'h00;
	endfunction

	// Cleared state; error scheme differs during and after reset
	task automatic chk_clear(input logic mid);
		cv(16'(lvl), 16'h0007);
		cf(&{col_inv, row_inv, wid_inv, tck_inv, tac_inv, cas_inv}, 1'b1);
		cf(lvl_inv & prim_inv, 1'b1);
		cv(16'(err), mid ? 16'h0003 : 16'h0000);
		cf(err_inv, mid);
		cf(ref_inv, mid);
		cv(width | 16'(col1) | 16'(tck), 16'h0000);
	endtask

	// Every low nibble alone, then unequal banks
	task automatic t_col;
		for (int i = 0; i < 16; i++) begin
			put(MGBD_OFS_COL, 8'(i));
			idle;
			cv(16'(col1), 16'(colx(4'(i))));
			cv(16'(col2), 16'(colx(4'(i))));
			cf(col_dif, 1'b0);
			cf(col_inv, colx(4'(i)) == 5'h00);
		end
		put(MGBD_OFS_COL, 8'h9A);
		idle;
		cv(16'(col1), 16'h000A);
		cv(16'(col2), 16'h0009);
		cf(col_dif, 1'b1);
		cf(col_inv, 1'b0);
		put(MGBD_OFS_COL, 8'h1F);
		idle;
		cv(16'(col2), 16'h0010);
		put(MGBD_OFS_COL, 8'h98);
		idle;
		cv(16'(col1), 16'h0008);
		cv(16'(col2), 16'h0009);
		put(MGBD_OFS_COL, 8'h3A);
		idle;
		cf(col_inv, 1'b1);
	endtask

	// Row count limits and two-byte width in either order
	task automatic t_rows_width;
		put(MGBD_OFS_ROWS, 8'h00);
		idle;
		cf(row_inv, 1'b1);
		put(MGBD_OFS_ROWS, 8'hFF);
		idle;
		cv(16'(rows), 16'h00FF);
		cf(row_inv, 1'b0);
		put(MGBD_OFS_WLO, 8'h48);
		put(MGBD_OFS_WHI, 8'h00);
		idle;
		cv(width, 16'h0048);
		cf(wid_inv, 1'b0);
		put(MGBD_OFS_WHI, 8'h01);
		put(MGBD_OFS_WLO, 8'h00);
		idle;
		cv(width, 16'h0100);
		cf(wid_inv, 1'b0);
		put(MGBD_OFS_WHI, 8'h00);
		idle;
		cf(wid_inv, 1'b1);
	endtask

	// All level codes, new-table code and one unused code
	task automatic t_level;
		for (int i = 0; i < 7; i++) begin
			put(MGBD_OFS_LVL, (i == 5) ? 8'hFF : 8'(i));
			idle;
			cv(16'(lvl), (i == 6) ? 16'h0007 : 16'(i));
			cf(lvl_inv, i > 4);
		end
	endtask

	// Nibble times, latency bitmap and ignored offsets
	task automatic t_time;
		put(MGBD_OFS_TCK, 8'h75);
		put(MGBD_OFS_TAC, 8'h54);
		idle;
		cv(16'(tck), 16'h004B);
		cv(16'(tac), 16'h0036);
		cf(tck_inv | tac_inv, 1'b0);
		put(MGBD_OFS_TCK, 8'hF9);
		put(MGBD_OFS_TAC, 8'h00);
		put(MGBD_OFS_CAS, 8'h07);
		idle;
		cv(16'(tck), 16'h009F);
		cf(tac_inv, 1'b1);
		cv(16'(cas), 16'h0003);
		put(MGBD_OFS_CAS, 8'hC0);
		idle;
		cv(16'(cas), 16'h0007);
		put(MGBD_OFS_CAS, 8'h06);
		idle;
		cv(16'(cas), 16'h0003);
		cf(cas_inv, 1'b0);
		put(MGBD_OFS_CAS, 8'h00);
		put(8'h0E, 8'h00);
		put(8'h03, 8'h00);
		idle;
		cf(cas_inv, 1'b1);
		cv(16'(tck), 16'h009F);
	endtask

	// Error scheme codes, two undefined ones
	task automatic t_err;
		for (int i = 0; i < 5; i++) begin
			put(MGBD_OFS_ERR, (i == 4) ? 8'hFF : 8'(i));
			idle;
			cv(16'(err), (i > 2) ? 16'h0003 : 16'(i));
			cf(err_inv, i > 2);
		end
	endtask

	// Refresh codes with the self flag toggling, then a spare code
	task automatic t_ref;
		for (int i = 0; i < 7; i++) begin
			put(MGBD_OFS_REF, {i[0], 7'(i)});
			idle;
			cv(16'(refc), (i == 6) ? 16'h0000 : 16'(i));
			cf(self_ref, i[0]);
			cf(ref_inv, i == 6);
		end
	endtask

	// Primary width, doubling flag, undefined width
	task automatic t_prim;
		put(MGBD_OFS_PWID, 8'h10);
		idle;
		cv(16'(prim), 16'h0010);
		cf(dbl | prim_inv, 1'b0);
		put(MGBD_OFS_PWID, 8'h84);
		idle;
		cv(16'(prim), 16'h0004);
		cf(dbl, 1'b1);
		put(MGBD_OFS_PWID, 8'h80);
		idle;
		cf(prim_inv & dbl, 1'b1);
	endtask

	// Reset in mid run clears everything again
	task automatic t_reset;
		@(posedge clock);
		rst_b <= 1'b0;
		#1;
		chk_clear(1'b1);
		@(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk_clear(1'b0);
	endtask

	// Counts, verdict and end of run
	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		send = 1'b0;
		s_ofs = 8'h00;
		s_dat = 8'h00;
		repeat (4) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk_clear(1'b0);
		t_col;
		t_rows_width;
		t_level;
		t_time;
		t_err;
		t_ref;
		t_prim;
		t_reset;
		results;
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		results;
	end
endmodule
`default_nettype wire
